// ===== common/lane_consts.svh
/*
 * Constants of the byte-lane steering slave: burst codes, answer codes,
 * buffer depth and reset values.
 * Assumes it is included by bare name wherever the numbers are needed.
 */
`ifndef LANE_CONSTS_SVH
`define LANE_CONSTS_SVH

// ******************************************************************
// Burst types and answers
// ******************************************************************
`define LANE_BURST_FIXED 2'h0
`define LANE_BURST_INCR  2'h1
`define LANE_BURST_WRAP  2'h2
`define LANE_RESP_OKAY   2'h0
`define LANE_RESP_SLVERR 2'h2

// ******************************************************************
// Sizes and reset values
// ******************************************************************
`define LANE_WFIFO_DEPTH 8
`define LANE_DATA_W      32
`define LANE_ADDR_W      10
`define LANE_RESET_BIT   1'h0

`endif

// ===== common/lane_pkg.sv
/*
 * Types shared by the byte-lane steering slave.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package lane_pkg;

   typedef logic [1:0] burst_t;
   typedef logic [2:0] size_t;
   typedef logic [7:0] len_t;
   typedef logic [1:0] resp_t;

   // Write channel states, one-hot
   typedef enum logic [2:0] {
      W_IDLE = 3'b001,
      W_DATA = 3'b010,
      W_RESP = 3'b100
   } wr_state_e;

   // Read channel states, one-hot
   typedef enum logic [1:0] {
      R_IDLE = 2'b01,
      R_DATA = 2'b10
   } rd_state_e;

endpackage

// ===== dv/lane_master_model.sv
/*
 * Master model driving the slave's five channels.
 * Assumes the bench fills wd/ws before a write and reads rq/rl after.
 */
`timescale 1ns/10ps
module lane_master_model
   import lane_pkg::*;
(
   // Clock
   input  wire logic         mclk_in,
   // Requests towards the slave
   output logic              awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in,
   output logic [9:0]        awaddr_in, araddr_in,
   output lane_pkg::len_t    awlen_in, arlen_in,
   output lane_pkg::size_t   awsize_in, arsize_in,
   output lane_pkg::burst_t  awburst_in, arburst_in,
   output logic [31:0]       wdata_in,
   output logic [3:0]        wstrb_in,
   // Answers from the slave
   input  wire logic         awready_out, wready_out, bvalid_out, arready_out,
   input  wire logic         rvalid_out, rlast_out,
   input  wire lane_pkg::resp_t bresp_out, rresp_out,
   input  wire logic [31:0]  rdata_out
);
   import lane_pkg::*;
   logic [31:0] wd [16];
   logic [3:0]  ws [16];
   logic [31:0] rq [16];
   logic        rl [16];
   resp_t       rr [16];

   // Nothing offered until the bench releases reset
   initial begin
      {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = '0;
      {awaddr_in, araddr_in, awlen_in, arlen_in} = '0;
      {awsize_in, arsize_in, awburst_in, arburst_in} = '0;
      wdata_in = '0;
      wstrb_in = '0;
   end

   // ******************************
   // Channel tasks
   // ******************************
   // Start address sent as given, low bits match strobes
   task automatic waddr(input logic [9:0] a, input len_t l, input size_t s, input burst_t b);
      @(posedge mclk_in);
      awvalid_in <= 1'b1;
      awaddr_in <= a;
      awlen_in <= l;
      awsize_in <= s;
      awburst_in <= b;
      do @(posedge mclk_in); while (awready_out !== 1'b1);
      awvalid_in <= 1'b0;
      awaddr_in <= ~a;
   endtask
   // Strobes only from the bench's permitted-lane table
   task automatic wdat(input int n);
      @(posedge mclk_in);
      for (int i = 0; i < n; i++) begin
         wvalid_in <= 1'b1;
         wdata_in <= wd[i];
         wstrb_in <= ws[i];
         do @(posedge mclk_in); while (wready_out !== 1'b1);
      end
      wvalid_in <= 1'b0;
      wdata_in <= ~wd[n-1]; // Released data never keeps the last value; wstrb_in keeps it
   endtask
   // A delay makes the answer side stall
   task automatic wresp(input int dly, output resp_t r);
      repeat (dly + 1) @(posedge mclk_in);
      bready_in <= 1'b1;
      do @(posedge mclk_in); while (bvalid_out !== 1'b1);
      r = bresp_out;
      bready_in <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input len_t l, input size_t s, input burst_t b,
                     output resp_t r);
      fork
         waddr(a, l, s, b);
         wdat(int'(l) + 1);
         wresp(0, r);
      join
   endtask
   // Read runs apart from writes, on its own channel
   task automatic rd(input logic [9:0] a, input len_t l, input size_t s, input burst_t b);
      @(posedge mclk_in);
      arvalid_in <= 1'b1;
      araddr_in <= a;
      arlen_in <= l;
      arsize_in <= s;
      arburst_in <= b;
      do @(posedge mclk_in); while (arready_out !== 1'b1);
      arvalid_in <= 1'b0;
      araddr_in <= ~a;
      @(posedge mclk_in); // One stalled cycle: the first beat must hold
      rready_in <= 1'b1;
      for (int i = 0; i <= int'(l); i++) begin
         do @(posedge mclk_in); while (rvalid_out !== 1'b1);
         rq[i] = rdata_out;
         rl[i] = rlast_out;
         rr[i] = rresp_out;
      end
      rready_in <= 1'b0;
   endtask
endmodule

// ===== dv/lane_slave_monitor.sv
/*
 * Checker on the lane slave ports: handshakes, holds, quiet reset.
 * Assumes one clock; bound to every lane_slave instance below.
 */
`timescale 1ns/10ps
`include "lane_consts.svh"
module lane_slave_monitor
   import lane_pkg::*;
#(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 10
) (
   // Clock and reset
   input wire logic              mclk_in,
   input wire logic              reset_n_in,
   // Write channels
   input wire logic              awvalid_in,
   input wire logic              awready_out,
   input wire logic              wvalid_in,
   input wire logic              wready_out,
   input wire logic              bvalid_out,
   input wire logic              bready_in,
   input wire lane_pkg::resp_t   bresp_out,
   // Read channels
   input wire logic              arvalid_in,
   input wire logic              arready_out,
   input wire lane_pkg::len_t    arlen_in,
   input wire logic              rvalid_out,
   input wire logic              rready_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire logic              rlast_out
);
   import lane_pkg::*;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!reset_n_in);

   // ******************************
   // Assertions
   // ******************************
   // Reset check cannot be disabled by reset itself
   rst_quiet_a:
      assert property (disable iff (1'b0) !reset_n_in |-> !bvalid_out && !rvalid_out)
         else $error("valid high during reset");
   aw_taken_a:
      assert property (awvalid_in && awready_out |=> !awready_out)
         else $error("write address ready stayed high");
   b_code_a:
      assert property (bvalid_out |-> bresp_out inside {`LANE_RESP_OKAY, `LANE_RESP_SLVERR})
         else $error("bad write answer code");
   b_hold_a:
      assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
         else $error("write answer dropped before taken");
   b_done_a:
      assert property (bvalid_out && bready_in |=> !bvalid_out ##1 awready_out)
         else $error("write answer close wrong");
   r_hold_a:
      assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out)
                       && $stable(rlast_out))
         else $error("read beat changed while stalled");
   r_first_a:
      assert property (arvalid_in && arready_out |=> rvalid_out
                       && (rlast_out == ($past(arlen_in) == 8'h00)))
         else $error("first read beat wrong");
   r_end_a:
      assert property (rvalid_out && rready_in && rlast_out |=> !rvalid_out ##1 arready_out)
         else $error("read burst close wrong");
   ar_busy_a:
      assert property (rvalid_out |-> !arready_out)
         else $error("read address taken mid burst");
   w_full_a:
      assert property ($fell(wready_out) |-> $past(wvalid_in))
         else $error("write ready fell without a push");

   // Main scenarios reached
   cover property (bvalid_out && bready_in && bresp_out == `LANE_RESP_SLVERR);
   cover property (rvalid_out && rready_in && rlast_out);
   cover property (!wready_out && !awready_out);
endmodule

bind lane_slave lane_slave_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mon (
   .mclk_in, .reset_n_in, .awvalid_in, .awready_out, .wvalid_in, .wready_out,
   .bvalid_out, .bready_in, .bresp_out, .arvalid_in, .arready_out, .arlen_in,
   .rvalid_out, .rready_in, .rdata_out, .rlast_out);

// ===== dv/lane_slave_tb.sv
/*
 * Self-checking bench for the lane slave and its write FIFO.
 * Assumes the master model drives every slave channel input from time zero.
 */
`timescale 1ns/10ps
`include "lane_consts.svh"
`define CHK(g, e) begin \
   cmp_count++; \
   if ((g) !== (e)) begin \
      num_errors++; \
      $display("[ERR] %0t got %h expected %h", $time, (g), (e)); \
   end \
end

module lane_slave_tb;
   import lane_pkg::*;
   logic        mclk_in, reset_n_in, awvalid_in, awready_out, wvalid_in, wready_out;
   logic        bvalid_out, bready_in, arvalid_in, arready_out, rvalid_out, rready_in;
   logic        rlast_out;
   logic [9:0]  awaddr_in, araddr_in;
   logic [31:0] wdata_in, rdata_out;
   logic [3:0]  wstrb_in;
   len_t        awlen_in, arlen_in;
   size_t       awsize_in, arsize_in;
   burst_t      awburst_in, arburst_in;
   resp_t       bresp_out, rresp_out;
   int          num_errors = 0;
   int          cmp_count = 0;
   int          cycles = 0;

   lane_slave u_dut (
      .mclk_in, .reset_n_in, .awvalid_in, .awready_out, .awaddr_in, .awlen_in,
      .awsize_in, .awburst_in, .wvalid_in, .wready_out, .wdata_in, .wstrb_in,
      .bvalid_out, .bready_in, .bresp_out, .arvalid_in, .arready_out, .araddr_in,
      .arlen_in, .arsize_in, .arburst_in, .rvalid_out, .rready_in, .rdata_out,
      .rresp_out, .rlast_out);
   lane_master_model u_mst (
      .mclk_in, .awvalid_in, .wvalid_in, .bready_in, .arvalid_in, .rready_in,
      .awaddr_in, .araddr_in, .awlen_in, .arlen_in, .awsize_in, .arsize_in,
      .awburst_in, .arburst_in, .wdata_in, .wstrb_in, .awready_out, .wready_out,
      .bvalid_out, .arready_out, .rvalid_out, .rlast_out, .bresp_out, .rdata_out,
      .rresp_out);

   // ******************************
   // Shared steps
   // ******************************
   task automatic wfull(input logic [9:0] a, input logic [31:0] d);
      resp_t r;
      u_mst.wd[0] = d;
      u_mst.ws[0] = 4'hf;
      u_mst.wr(a, 8'h00, 3'h2, `LANE_BURST_INCR, r);
      `CHK(r, `LANE_RESP_OKAY)
   endtask
   task automatic rchk(input logic [9:0] a, input logic [31:0] e);
      u_mst.rd(a, 8'h00, 3'h2, `LANE_BURST_INCR);
      `CHK(u_mst.rq[0], e)
      `CHK(u_mst.rr[0], `LANE_RESP_OKAY)
   endtask

   // ******************************
   // Scenarios
   // ******************************
   // Byte beats walk lanes 0..3 then lane 0 of the next word
   task automatic t_narrow;
      resp_t r;
      wfull(10'h004, 32'hffffffff);
      for (int i = 0; i < 5; i++) begin
         u_mst.wd[i] = {4{8'h11 * 8'(i + 1)}};
         u_mst.ws[i] = 4'h1 << (i % 4);
      end
      u_mst.wr(10'h000, 8'h04, 3'h0, `LANE_BURST_INCR, r);
      rchk(10'h000, 32'h44332211);
      rchk(10'h004, 32'hffffff55);
   endtask
   // Fixed byte burst lands on one lane; fixed read repeats one word
   task automatic t_fixed;
      resp_t r;
      wfull(10'h008, 32'h0);
      for (int i = 0; i < 3; i++) begin
         u_mst.wd[i] = {4{8'ha1 + 8'(i)}};
         u_mst.ws[i] = 4'h4;
      end
      u_mst.wr(10'h00a, 8'h02, 3'h0, `LANE_BURST_FIXED, r);
      u_mst.rd(10'h008, 8'h02, 3'h2, `LANE_BURST_FIXED);
      for (int i = 0; i < 3; i++) begin
         `CHK(u_mst.rq[i], 32'h00a30000)
      end
      `CHK(u_mst.rl[2], 1'b1)
   endtask
   // Sparse strobes leave the unstrobed lanes alone
   task automatic t_strobe;
      resp_t r;
      wfull(10'h00c, 32'h0);
      u_mst.wd[0] = 32'hdeadbeef;
      u_mst.ws[0] = 4'b0101;
      u_mst.wr(10'h00c, 8'h00, 3'h2, `LANE_BURST_INCR, r);
      rchk(10'h00c, 32'h00ad00ef);
   endtask
   // Wrap from 0x34 closes at 0x30
   task automatic t_wrap;
      resp_t r;
      for (int i = 0; i < 4; i++) begin
         u_mst.wd[i] = 32'(i + 1);
         u_mst.ws[i] = 4'hf;
      end
      u_mst.wr(10'h034, 8'h03, 3'h2, `LANE_BURST_WRAP, r);
      u_mst.rd(10'h030, 8'h03, 3'h2, `LANE_BURST_INCR);
      for (int i = 0; i < 4; i++) begin
         `CHK(u_mst.rq[i], 32'((i + 3) % 4 + 1))
      end
      `CHK({u_mst.rl[2], u_mst.rl[3]}, 2'b01)
   endtask
   // Unaligned start: first beat keeps lanes 1..3, then aligned words
   task automatic t_unal;
      resp_t r;
      wfull(10'h040, 32'h0);
      u_mst.wd[0] = 32'h11223344;
      u_mst.ws[0] = 4'he;
      u_mst.wd[1] = 32'h55667788;
      u_mst.ws[1] = 4'hf;
      u_mst.wr(10'h041, 8'h01, 3'h2, `LANE_BURST_INCR, r);
      rchk(10'h040, 32'h11223300);
      rchk(10'h044, 32'h55667788);
   endtask
   // Beat wider than the bus is refused and memory kept
   task automatic t_slverr;
      resp_t r;
      wfull(10'h050, 32'h12345678);
      u_mst.wd[0] = 32'h0;
      u_mst.ws[0] = 4'hf;
      u_mst.wr(10'h050, 8'h00, 3'h3, `LANE_BURST_INCR, r);
      `CHK(r, `LANE_RESP_SLVERR)
      rchk(10'h050, 32'h12345678);
      u_mst.rd(10'h050, 8'h00, 3'h3, `LANE_BURST_INCR);
      `CHK(u_mst.rr[0], `LANE_RESP_SLVERR)
   endtask
   // Fill the FIFO with no address, then drain it beside a read, answer stalled
   task automatic t_fifo;
      resp_t r;
      for (int i = 0; i < 8; i++) begin
         u_mst.wd[i] = 32'h600 + 32'(i);
         u_mst.ws[i] = 4'hf;
      end
      u_mst.wdat(8);
      @(posedge mclk_in);
      `CHK(wready_out, 1'b0)
      fork
         u_mst.waddr(10'h060, 8'h07, 3'h2, `LANE_BURST_INCR);
         u_mst.wresp(12, r);
         u_mst.rd(10'h030, 8'h03, 3'h2, `LANE_BURST_INCR);
      join
      `CHK(r, `LANE_RESP_OKAY)
      `CHK(u_mst.rq[0], 32'h4)
      rchk(10'h060, 32'h600);
      rchk(10'h07c, 32'h607);
   endtask

   task automatic summarize;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ******************************
   // Clock, reset, sequence
   // ******************************
   initial begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end
   // Hang guard: far above the roughly 130 cycles the scenarios need
   always @(posedge mclk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         summarize;
      end
   end
   initial begin
      reset_n_in = 1'b0;
      repeat (4) @(posedge mclk_in);
      `CHK({bvalid_out, rvalid_out}, 2'b00)
      reset_n_in <= 1'b1;
      t_narrow;
      t_fixed;
      t_strobe;
      t_wrap;
      t_unal;
      t_slverr;
      t_fifo;
      summarize;
   end
endmodule

// ===== hw/lane_slave.sv
/*
 * Memory slave with byte-lane steering on writes and whole-word reads, on separate read and write data
 * channels, plus the write data FIFO that stands in front of it.
 * Assumes a master on the same clock that keeps the bus rules on its side.
 */
`timescale 1ns/10ps
`include "lane_consts.svh"

// ******************************************************************
// Write data FIFO
// ******************************************************************
module lane_wfifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = `LANE_WFIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             mclk_in,
   input  wire logic             reset_n_in,
   // Filling side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Draining side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_reg [DEPTH];
   logic [PW-1:0]    wr_ptr_reg;
   logic [PW-1:0]    rd_ptr_reg;
   logic [PW:0]      count_reg;
   logic             not_full_reg;
   logic             push;
   logic             pop;

   // Refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("lane_wfifo: DEPTH must be a power of two above one");
   end

   assign push          = in_valid_in && not_full_reg;
   assign pop           = out_ready_in && (count_reg != '0);
   assign in_ready_out  = not_full_reg;
   assign out_valid_out = (count_reg != '0);
   assign out_data_out  = store_reg[rd_ptr_reg];

   // Storage has no reset; only pointers matter
   always_ff @(posedge mclk_in) begin
      if (push)
         store_reg[wr_ptr_reg] <= in_data_in;
   end

   // Pointers and level; ready is registered so it never follows an input
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_ptr_reg   <= '0;
         rd_ptr_reg   <= '0;
         count_reg    <= '0;
         not_full_reg <= `LANE_RESET_BIT;
      end else begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + PW'(1);
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + PW'(1);
         count_reg    <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
         not_full_reg <= (count_reg + (PW+1)'(push) - (PW+1)'(pop)) != (PW+1)'(DEPTH);
      end
   end
endmodule

module lane_slave
   import lane_pkg::*;
#(
   parameter int DATA_W = `LANE_DATA_W,
   parameter int ADDR_W = `LANE_ADDR_W
) (
   // Clock and reset
   input  wire logic                  mclk_in,
   input  wire logic                  reset_n_in,
   // Write address channel
   input  wire logic                  awvalid_in,
   output logic                       awready_out,
   input  wire logic [ADDR_W-1:0]     awaddr_in,
   input  wire lane_pkg::len_t        awlen_in,
   input  wire lane_pkg::size_t       awsize_in,
   input  wire lane_pkg::burst_t      awburst_in,
   // Write data channel
   input  wire logic                  wvalid_in,
   output logic                       wready_out,
   input  wire logic [DATA_W-1:0]     wdata_in,
   input  wire logic [DATA_W/8-1:0]   wstrb_in,
   // Write response channel
   output logic                       bvalid_out,
   input  wire logic                  bready_in,
   output lane_pkg::resp_t            bresp_out,
   // Read address channel
   input  wire logic                  arvalid_in,
   output logic                       arready_out,
   input  wire logic [ADDR_W-1:0]     araddr_in,
   input  wire lane_pkg::len_t        arlen_in,
   input  wire lane_pkg::size_t       arsize_in,
   input  wire lane_pkg::burst_t      arburst_in,
   // Read data channel
   output logic                       rvalid_out,
   input  wire logic                  rready_in,
   output logic [DATA_W-1:0]          rdata_out,
   output lane_pkg::resp_t            rresp_out,
   output logic                       rlast_out
);
   import lane_pkg::*;

   localparam int NB    = DATA_W / 8;
   localparam int LSB   = $clog2(NB);
   localparam int WORDS = 1 << (ADDR_W - LSB);
   localparam int FW    = DATA_W + NB;

   // Refuse bus widths the lane arithmetic cannot serve
   if (DATA_W < 8 || (DATA_W & (DATA_W - 1)) != 0 || DATA_W > 1024 || ADDR_W <= LSB) begin
      $error("lane_slave: DATA_W must be a power of two, 8..1024, below the address");
   end

   // ******************************************************************
   // Lane arithmetic
   // ******************************************************************
   // Beat address rounded down to its own size
   function automatic logic [ADDR_W-1:0] align_down(input logic [ADDR_W-1:0] a,
                                                    input size_t s);
      align_down = a & ~((ADDR_W'(1) << s) - ADDR_W'(1));
   endfunction

   // Address of the following beat
   function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                   input size_t s, input len_t l,
                                                   input burst_t b);
      logic [ADDR_W-1:0] inc;
      logic [ADDR_W-1:0] wmask;
      inc   = align_down(a, s) + (ADDR_W'(1) << s);
      wmask = ((ADDR_W'(l) + ADDR_W'(1)) << s) - ADDR_W'(1);
      if (b == `LANE_BURST_FIXED)
         next_addr = a;
      else if (b == `LANE_BURST_WRAP)
         next_addr = (a & ~wmask) | (inc & wmask);
      else
         next_addr = inc;
   endfunction

   // Lanes a beat may use: aligned address modulo bus bytes, size wide
   function automatic logic [NB-1:0] lane_mask(input logic [ADDR_W-1:0] a, input size_t s);
      logic [ADDR_W-1:0] off;
      logic [ADDR_W-1:0] wid;
      off = align_down(a, s) & ADDR_W'(NB - 1);
      wid = ADDR_W'(1) << s;
      for (int i = 0; i < NB; i++)
         lane_mask[i] = (ADDR_W'(i) >= off) && (ADDR_W'(i) < off + wid);
   endfunction

   // A beat wider than the bus is answered with an error; a write is never executed, a read still returns the word
   function automatic logic too_wide(input size_t s);
      too_wide = (32'(s) > LSB);
   endfunction

   // ******************************************************************
   // Storage and write data buffer
   // ******************************************************************
   // Byte n of a word holds byte address n, so a little-endian core fits
   logic [DATA_W-1:0] mem_reg [WORDS];

   logic              fifo_valid;
   logic              fifo_ready;
   logic [FW-1:0]     fifo_data;
   logic [DATA_W-1:0] beat_data;
   logic [NB-1:0]     beat_strb;

   lane_wfifo #(
      .WIDTH (FW),
      .DEPTH (`LANE_WFIFO_DEPTH)
   ) u_wfifo (
      .mclk_in       (mclk_in),
      .reset_n_in    (reset_n_in),
      .in_valid_in   (wvalid_in),
      .in_ready_out  (wready_out),
      .in_data_in    ({wstrb_in, wdata_in}),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_ready),
      .out_data_out  (fifo_data)
   );

   assign beat_data = fifo_data[DATA_W-1:0];
   assign beat_strb = fifo_data[FW-1:DATA_W];

   // ******************************************************************
   // Write channel
   // ******************************************************************
   wr_state_e         wr_state_reg;
   logic [ADDR_W-1:0] wr_addr_reg;
   size_t             wr_size_reg;
   len_t              wr_len_reg;
   burst_t            wr_burst_reg;
   len_t              wr_cnt_reg;
   logic              wr_err_reg;
   logic              awready_reg;
   logic              bvalid_reg;
   resp_t             bresp_reg;
   logic              wr_beat;
   logic [NB-1:0]     wr_lanes;

   assign fifo_ready  = (wr_state_reg == W_DATA);
   assign wr_beat     = fifo_ready && fifo_valid;
   assign wr_lanes    = lane_mask(wr_addr_reg, wr_size_reg);
   assign awready_out = awready_reg;
   assign bvalid_out  = bvalid_reg;
   assign bresp_out   = bresp_reg;

   // Bytes land only where strobe and permitted lanes agree; the start
   // offset is not trusted beyond that mask
   always_ff @(posedge mclk_in) begin
      if (wr_beat && !wr_err_reg) begin
         for (int n = 0; n < NB; n++) begin
            if (beat_strb[n] && wr_lanes[n])
               mem_reg[wr_addr_reg[ADDR_W-1:LSB]][8*n +: 8] <= beat_data[8*n +: 8];
         end
      end
   end

   // Address acceptance, beat counting and response
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wr_state_reg <= W_IDLE;
         wr_addr_reg  <= '0;
         wr_size_reg  <= '0;
         wr_len_reg   <= '0;
         wr_burst_reg <= `LANE_BURST_FIXED;
         wr_cnt_reg   <= '0;
         wr_err_reg   <= `LANE_RESET_BIT;
         awready_reg  <= `LANE_RESET_BIT;
         bvalid_reg   <= `LANE_RESET_BIT;
         bresp_reg    <= `LANE_RESP_OKAY;
      end else begin
         unique case (wr_state_reg)
            W_IDLE: begin
               awready_reg <= 1'b1;
               if (awvalid_in && awready_reg) begin
                  awready_reg  <= 1'b0;
                  wr_addr_reg  <= awaddr_in;
                  wr_size_reg  <= awsize_in;
                  wr_len_reg   <= awlen_in;
                  wr_burst_reg <= awburst_in;
                  wr_err_reg   <= too_wide(awsize_in);
                  wr_cnt_reg   <= '0;
                  wr_state_reg <= W_DATA;
               end
            end
            W_DATA: begin
               if (wr_beat) begin
                  wr_addr_reg <= next_addr(wr_addr_reg, wr_size_reg, wr_len_reg, wr_burst_reg);
                  wr_cnt_reg  <= wr_cnt_reg + 8'h01;
                  if (wr_cnt_reg == wr_len_reg) begin
                     bvalid_reg   <= 1'b1;
                     bresp_reg    <= wr_err_reg ? `LANE_RESP_SLVERR : `LANE_RESP_OKAY;
                     wr_state_reg <= W_RESP;
                  end
               end
            end
            W_RESP: begin
               if (bready_in) begin
                  bvalid_reg   <= 1'b0;
                  wr_state_reg <= W_IDLE;
               end
            end
         endcase
      end
   end

   // ******************************************************************
   // Read channel, free to complete in the same cycle as a write beat
   // ******************************************************************
   rd_state_e         rd_state_reg;
   logic [ADDR_W-1:0] rd_addr_reg;
   size_t             rd_size_reg;
   len_t              rd_len_reg;
   burst_t            rd_burst_reg;
   len_t              rd_cnt_reg;
   logic              arready_reg;
   logic              rvalid_reg;
   logic              rlast_reg;
   resp_t             rresp_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [ADDR_W-1:0] rd_next;

   assign rd_next     = next_addr(rd_addr_reg, rd_size_reg, rd_len_reg, rd_burst_reg);
   assign arready_out = arready_reg;
   assign rvalid_out  = rvalid_reg;
   assign rlast_out   = rlast_reg;
   assign rresp_out   = rresp_reg;
   assign rdata_out   = rdata_reg;

   // Whole word returned; the master picks its lanes from the address
   always_ff @(posedge mclk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_state_reg <= R_IDLE;
         rd_addr_reg  <= '0;
         rd_size_reg  <= '0;
         rd_len_reg   <= '0;
         rd_burst_reg <= `LANE_BURST_FIXED;
         rd_cnt_reg   <= '0;
         arready_reg  <= `LANE_RESET_BIT;
         rvalid_reg   <= `LANE_RESET_BIT;
         rlast_reg    <= `LANE_RESET_BIT;
         rresp_reg    <= `LANE_RESP_OKAY;
         rdata_reg    <= '0;
      end else begin
         unique case (rd_state_reg)
            R_IDLE: begin
               arready_reg <= 1'b1;
               if (arvalid_in && arready_reg) begin
                  arready_reg  <= 1'b0;
                  rd_addr_reg  <= araddr_in;
                  rd_size_reg  <= arsize_in;
                  rd_len_reg   <= arlen_in;
                  rd_burst_reg <= arburst_in;
                  rd_cnt_reg   <= '0;
                  rdata_reg    <= mem_reg[araddr_in[ADDR_W-1:LSB]];
                  rresp_reg    <= too_wide(arsize_in) ? `LANE_RESP_SLVERR : `LANE_RESP_OKAY;
                  rlast_reg    <= (arlen_in == 8'h00);
                  rvalid_reg   <= 1'b1;
                  rd_state_reg <= R_DATA;
               end
            end
            R_DATA: begin
               if (rready_in) begin
                  if (rlast_reg) begin
                     rvalid_reg   <= 1'b0;
                     rlast_reg    <= 1'b0;
                     rd_state_reg <= R_IDLE;
                  end else begin
                     rd_addr_reg <= rd_next;
                     rdata_reg   <= mem_reg[rd_next[ADDR_W-1:LSB]];
                     rd_cnt_reg  <= rd_cnt_reg + 8'h01;
                     rlast_reg   <= (rd_cnt_reg + 8'h01 == rd_len_reg);
                  end
               end
            end
         endcase
      end
   end
endmodule
